// file: cdrlc_cfg.svh
`ifndef CDRLC_CFG_SVH
`define CDRLC_CFG_SVH

// Clock and timing
`define CDRLC_PCLK_MHZ 250
`define CDRLC_LOS_RESP_NS 300
`define CDRLC_LOS_RESP_CYC ((`CDRLC_LOS_RESP_NS * `CDRLC_PCLK_MHZ) / 1000)

// Lock detector
`define CDRLC_ACQ_PPM 500
`define CDRLC_REL_PPM 1000
`define CDRLC_PPM_DEN 1000000
`define CDRLC_WIN_REFS 20000
`define CDRLC_NOM_NAT_NUM 7
`define CDRLC_NOM_NAT_DEN 10
`define CDRLC_NOM_FEC_NUM 3
`define CDRLC_NOM_FEC_DEN 4
`define CDRLC_CNT_W 16
`define CDRLC_PRE_W 4

// Register offsets
`define CDRLC_ADDR_CTRL 8'h00
`define CDRLC_ADDR_STATUS 8'h04
`define CDRLC_ADDR_EVENT 8'h08
`define CDRLC_ADDR_MASK 8'h0c
`define CDRLC_ADDR_COUNT 8'h10

// Control fields
`define CDRLC_CTRL_W 9
`define CDRLC_CTRL_RESET 9'h000
`define CDRLC_CTRL_SRC 0
`define CDRLC_CTRL_FSEL_LO 1
`define CDRLC_CTRL_RATE_LO 3
`define CDRLC_CTRL_MUTE 5
`define CDRLC_CTRL_SKIP 6
`define CDRLC_CTRL_LOOP 7
`define CDRLC_CTRL_AUTOMUTE 8

// Event, mask and status fields
`define CDRLC_EV_W 3
`define CDRLC_EV_RESET 3'h0
`define CDRLC_EV_LOS 0
`define CDRLC_EV_LOL 1
`define CDRLC_EV_LOCK 2
`define CDRLC_ST_LOS 0
`define CDRLC_ST_LOL 1
`define CDRLC_ST_PHASE 2

`endif

// file: cdrlc_pkg.sv
`include "cdrlc_cfg.svh"

package cdrlc_pkg;

  typedef enum logic {cdrlc_freq_loop, cdrlc_phase_loop} cdrlc_loop_t;

  typedef struct packed {
    logic [`CDRLC_CTRL_W-1:0] ctrl;
    logic [`CDRLC_EV_W-1:0] mask;
    logic [`CDRLC_EV_W-1:0] event_bits;
    logic [31:0] prdata;
    logic los;
    cdrlc_loop_t loop_owner;
    logic ref_prev;
    logic osc_prev;
    logic [`CDRLC_PRE_W-1:0] prediv;
    logic [`CDRLC_CNT_W-1:0] win_cnt;
    logic [`CDRLC_CNT_W-1:0] osc_cnt;
    logic [`CDRLC_CNT_W-1:0] last_cnt;
    logic data_out;
    logic clk_out;
    logic feed;
  } cdrlc_state_t;

endpackage

// file: cdrlc_sync3.sv
`timescale 1ns/1ps

module cdrlc_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous in, filtered out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cdrlc_sync_st_t;

  cdrlc_sync_st_t s;
  cdrlc_sync_st_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // A bit moves only once the second and third stages agree
    next_s.q = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule // cdrlc_sync3

// file: cdrlc_top.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cdrlc_cfg.svh"

// Contract
// - Signal-lost flag high below detect threshold
// - Signal-lost flag follows input within 300 ns
// - Source high: frequency select picks reference divider
// - Source low: crystal used, select ignored
// - Reference choice independent of data rate
// - Within 500 ppm: clear lock-lost, phase loop
// - Beyond 0.1%: set lock-lost, frequency loop
// - Mute forces clock and data outputs zero
// - Retime skip routes quantizer to data out
// - Test loop feeds recovery from test data
// - Rate select picks recovered data rate
// - Lock-lost high while frequency loop controls
module cdrlc_top #(
  parameter int WIN_REFS = `CDRLC_WIN_REFS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pins
  input wire logic los_comparator_in,
  input wire logic ref_clock_in,
  input wire logic crystal_pin_a,
  input wire logic osc_div_in,
  // Serial datapath
  input wire logic quantizer_data_in,
  input wire logic test_data_in,
  input wire logic cdr_data_in,
  input wire logic cdr_clk_in,
  output logic cdr_feed_data,
  output logic recovered_data_out,
  output logic recovered_clk_out,
  // Status and loop control
  output logic signal_lost_flag,
  output logic lock_lost_flag,
  output logic phase_loop_enable,
  output logic [1:0] rate_div_select,
  output logic [1:0] ref_divider_select,
  output logic irq
);

  localparam logic [`CDRLC_CNT_W-1:0] WIN_LAST = `CDRLC_CNT_W'(WIN_REFS - 1);
  localparam int NOM_NAT = (WIN_REFS * `CDRLC_NOM_NAT_NUM) / `CDRLC_NOM_NAT_DEN;
  localparam int NOM_FEC = (WIN_REFS * `CDRLC_NOM_FEC_NUM) / `CDRLC_NOM_FEC_DEN;
  localparam int ACQ_NAT = (NOM_NAT * `CDRLC_ACQ_PPM) / `CDRLC_PPM_DEN;
  localparam int ACQ_FEC = (NOM_FEC * `CDRLC_ACQ_PPM) / `CDRLC_PPM_DEN;
  localparam int REL_NAT = (NOM_NAT * `CDRLC_REL_PPM) / `CDRLC_PPM_DEN;
  localparam int REL_FEC = (NOM_FEC * `CDRLC_REL_PPM) / `CDRLC_PPM_DEN;
  localparam int LOS_CYC = `CDRLC_LOS_RESP_CYC;

  cdrlc_pkg::cdrlc_state_t s;
  cdrlc_pkg::cdrlc_state_t next_s;

  logic [3:0] pin_q;
  logic los_in;
  logic ref_pin;
  logic osc_pin;
  logic ref_src;
  logic [1:0] fsel_eff;
  logic fec_rate;
  logic [`CDRLC_PRE_W-1:0] pre_top;
  logic ref_edge;
  logic osc_edge;
  logic tick;
  logic win_end;
  logic [`CDRLC_CNT_W-1:0] meas;
  logic [`CDRLC_CNT_W-1:0] nom;
  logic [`CDRLC_CNT_W-1:0] acq_thr;
  logic [`CDRLC_CNT_W-1:0] rel_thr;
  logic [`CDRLC_CNT_W-1:0] err;
  logic skip;
  logic loop_eff;
  logic mute;
  logic setup;
  logic access;
  logic mapped;
  logic [`CDRLC_EV_W-1:0] ev_set;
  logic [`CDRLC_EV_W-1:0] ev_clr;

  cdrlc_sync3 #(
    .W(4)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({osc_div_in, crystal_pin_a, ref_clock_in, los_comparator_in}),
    .q(pin_q)
  );

  assign los_in = pin_q[0];
  assign osc_pin = pin_q[3];
  assign ref_src = s.ctrl[`CDRLC_CTRL_SRC];
  // Crystal runs at the base rate, so its divider is always one
  assign ref_pin = ref_src ? pin_q[1] : pin_q[2];
  assign fsel_eff = ref_src ? s.ctrl[`CDRLC_CTRL_FSEL_LO +: 2] : 2'b00;
  assign pre_top = (`CDRLC_PRE_W'(1) << fsel_eff) - `CDRLC_PRE_W'(1);
  assign ref_edge = ref_pin & ~s.ref_prev;
  assign osc_edge = osc_pin & ~s.osc_prev;
  assign tick = ref_edge && (s.prediv == pre_top);
  assign win_end = tick && (s.win_cnt == WIN_LAST);
  assign meas = s.osc_cnt + `CDRLC_CNT_W'(osc_edge);

  // Window is timed on the base reference alone, so rate never moves it
  assign fec_rate = s.ctrl[`CDRLC_CTRL_RATE_LO + 1];
  assign nom = fec_rate ? `CDRLC_CNT_W'(NOM_FEC) : `CDRLC_CNT_W'(NOM_NAT);
  assign acq_thr = fec_rate ? `CDRLC_CNT_W'(ACQ_FEC) : `CDRLC_CNT_W'(ACQ_NAT);
  assign rel_thr = fec_rate ? `CDRLC_CNT_W'(REL_FEC) : `CDRLC_CNT_W'(REL_NAT);
  assign err = (meas >= nom) ? (meas - nom) : (nom - meas);

  // Both test modes at once is undefined; bypass wins to stay deterministic
  assign skip = s.ctrl[`CDRLC_CTRL_SKIP];
  assign loop_eff = s.ctrl[`CDRLC_CTRL_LOOP] & ~skip;
  assign mute = s.ctrl[`CDRLC_CTRL_MUTE] | (s.ctrl[`CDRLC_CTRL_AUTOMUTE] & s.los);

  assign setup = psel & ~penable;
  assign access = psel & penable;

  always_comb
  begin
    if (paddr == `CDRLC_ADDR_CTRL)
    begin
      mapped = 1'b1;
    end
    else if (paddr == `CDRLC_ADDR_STATUS)
    begin
      mapped = 1'b1;
    end
    else if (paddr == `CDRLC_ADDR_EVENT)
    begin
      mapped = 1'b1;
    end
    else if (paddr == `CDRLC_ADDR_MASK)
    begin
      mapped = 1'b1;
    end
    else if (paddr == `CDRLC_ADDR_COUNT)
    begin
      mapped = 1'b1;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  always_comb
  begin
    next_s = s;
    ev_set = '0;
    ev_clr = '0;
    next_s.ref_prev = ref_pin;
    next_s.osc_prev = osc_pin;
    next_s.los = los_in;
    ev_set[`CDRLC_EV_LOS] = los_in & ~s.los;

    if (ref_edge)
    begin
      next_s.prediv = tick ? '0 : s.prediv + `CDRLC_PRE_W'(1);
    end
    next_s.osc_cnt = meas;
    if (tick)
    begin
      next_s.win_cnt = win_end ? '0 : s.win_cnt + `CDRLC_CNT_W'(1);
    end
    if (win_end)
    begin
      next_s.last_cnt = meas;
      next_s.osc_cnt = '0;
      case (s.loop_owner)
        cdrlc_pkg::cdrlc_freq_loop:
        begin
          if (err <= acq_thr)
          begin
            next_s.loop_owner = cdrlc_pkg::cdrlc_phase_loop;
            ev_set[`CDRLC_EV_LOCK] = 1'b1;
          end
        end
        cdrlc_pkg::cdrlc_phase_loop:
        begin
          if (err > rel_thr)
          begin
            next_s.loop_owner = cdrlc_pkg::cdrlc_freq_loop;
            ev_set[`CDRLC_EV_LOL] = 1'b1;
          end
        end
        default:
        begin
          next_s.loop_owner = cdrlc_pkg::cdrlc_freq_loop;
        end
      endcase
    end

    // Read data is staged in setup so it is stable through access
    if (setup)
    begin
      next_s.prdata = '0;
      if (paddr == `CDRLC_ADDR_CTRL)
      begin
        next_s.prdata[`CDRLC_CTRL_W-1:0] = s.ctrl;
      end
      else if (paddr == `CDRLC_ADDR_STATUS)
      begin
        next_s.prdata[`CDRLC_ST_LOS] = s.los;
        next_s.prdata[`CDRLC_ST_LOL] = lock_lost_flag;
        next_s.prdata[`CDRLC_ST_PHASE] = phase_loop_enable;
      end
      else if (paddr == `CDRLC_ADDR_EVENT)
      begin
        next_s.prdata[`CDRLC_EV_W-1:0] = s.event_bits;
      end
      else if (paddr == `CDRLC_ADDR_MASK)
      begin
        next_s.prdata[`CDRLC_EV_W-1:0] = s.mask;
      end
      else if (paddr == `CDRLC_ADDR_COUNT)
      begin
        next_s.prdata[`CDRLC_CNT_W-1:0] = s.last_cnt;
      end
    end

    if (access && pwrite)
    begin
      if (paddr == `CDRLC_ADDR_CTRL)
      begin
        next_s.ctrl = pwdata[`CDRLC_CTRL_W-1:0];
      end
      else if (paddr == `CDRLC_ADDR_MASK)
      begin
        next_s.mask = pwdata[`CDRLC_EV_W-1:0];
      end
    end
    else if (access && (paddr == `CDRLC_ADDR_EVENT))
    begin
      ev_clr = s.event_bits;
    end
    // A new event in the clearing cycle survives
    next_s.event_bits = (s.event_bits & ~ev_clr) | ev_set;

    next_s.clk_out = mute ? 1'b0 : cdr_clk_in;
    if (mute)
    begin
      next_s.data_out = 1'b0;
    end
    else if (skip)
    begin
      next_s.data_out = quantizer_data_in;
    end
    else
    begin
      next_s.data_out = cdr_data_in;
    end
    next_s.feed = loop_eff ? test_data_in : quantizer_data_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.ctrl <= `CDRLC_CTRL_RESET;
      s.mask <= `CDRLC_EV_RESET;
      s.event_bits <= `CDRLC_EV_RESET;
      s.loop_owner <= cdrlc_pkg::cdrlc_freq_loop;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign signal_lost_flag = s.los;
  assign lock_lost_flag = (s.loop_owner == cdrlc_pkg::cdrlc_freq_loop);
  assign phase_loop_enable = ~lock_lost_flag;
  assign rate_div_select = s.ctrl[`CDRLC_CTRL_RATE_LO +: 2];
  assign ref_divider_select = fsel_eff;
  assign recovered_data_out = s.data_out;
  assign recovered_clk_out = s.clk_out;
  assign cdr_feed_data = s.feed;
  assign irq = |(s.event_bits & s.mask);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_window_good;
    win_end && (err <= acq_thr);
  endsequence

  sequence s_window_bad;
    win_end && (err > rel_thr);
  endsequence

  a_los_follow_rise: assert property ($rose(los_comparator_in) ##1 los_comparator_in [*8]
    |-> ##[0:LOS_CYC] signal_lost_flag) else $error("signal lost flag late");
  a_los_follow_fall: assert property ($fell(los_comparator_in) ##1 !los_comparator_in [*8]
    |-> ##[0:LOS_CYC] !signal_lost_flag) else $error("signal lost flag stuck");
  a_lock_acquire: assert property (lock_lost_flag ##0 s_window_good |=> !lock_lost_flag
    && phase_loop_enable) else $error("lock not acquired");
  a_lock_release: assert property (!lock_lost_flag ##0 s_window_bad |=> lock_lost_flag
    && s.event_bits[`CDRLC_EV_LOL]) else $error("lock not released");
  a_lock_hold: assert property (!lock_lost_flag && !win_end |=> !lock_lost_flag)
    else $error("lock dropped outside window");
  a_mute_zero: assert property (mute |=> !recovered_data_out && !recovered_clk_out)
    else $error("mute did not zero outputs");
  a_skip_path: assert property (!mute && skip |=> recovered_data_out
    == $past(quantizer_data_in)) else $error("bypass path wrong");
  a_loop_feed: assert property (s.ctrl[`CDRLC_CTRL_LOOP] && !skip |=> cdr_feed_data
    == $past(test_data_in)) else $error("test loop feed wrong");
  a_xtal_select: assert property (!ref_src |-> ref_divider_select == 2'b00)
    else $error("crystal mode used frequency select");
  a_ref_select: assert property (ref_src |-> ref_divider_select
    == s.ctrl[`CDRLC_CTRL_FSEL_LO +: 2]) else $error("reference divider wrong");
  a_rate_select: assert property (access && pwrite && paddr == `CDRLC_ADDR_CTRL
    |=> rate_div_select == $past(pwdata[`CDRLC_CTRL_RATE_LO +: 2]))
    else $error("rate select not applied");

endmodule // cdrlc_top

// file: cdrlc_far_end.sv
`timescale 1ns/1ps

module cdrlc_far_end (
  // Clock
  input wire logic pclk,
  // Half periods in pclk cycles
  input wire logic [7:0] ref_half,
  input wire logic [7:0] osc_half,
  // Clock pins
  output logic ref_clock_in,
  output logic crystal_pin_a,
  output logic osc_div_in
);
  logic [7:0] ref_cnt = 8'h00;
  logic [7:0] xo_cnt = 8'h00;
  logic [7:0] osc_cnt = 8'h00;

  initial
  begin
    ref_clock_in = 1'b0;
    crystal_pin_a = 1'b0;
    osc_div_in = 1'b0;
  end

  // Jitter-free periods, well inside the accuracy limit
  always @(posedge pclk)
  begin
    ref_cnt <= (ref_cnt + 8'h01 >= ref_half) ? 8'h00 : ref_cnt + 8'h01;
    if (ref_cnt + 8'h01 >= ref_half)
      ref_clock_in <= ~ref_clock_in;
    // Crystal at base rate: 84 cycles a period
    xo_cnt <= (xo_cnt == 8'd41) ? 8'h00 : xo_cnt + 8'h01;
    if (xo_cnt == 8'd41)
      crystal_pin_a <= ~crystal_pin_a;
    osc_cnt <= (osc_cnt + 8'h01 >= osc_half) ? 8'h00 : osc_cnt + 8'h01;
    if (osc_cnt + 8'h01 >= osc_half)
      osc_div_in <= ~osc_div_in;
  end
endmodule // cdrlc_far_end

// file: tb_cdr_lock_and_path_control.sv
`timescale 1ns/1ps
`include "cdrlc_cfg.svh"

module tb_cdr_lock_and_path_control;
  localparam int WIN = 40;
  localparam int WCYC = WIN * 84;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic los_in = 1'b0;
  logic quant = 1'b0;
  logic tdata = 1'b0;
  logic cdata = 1'b0;
  logic cclk = 1'b0;
  logic [7:0] ref_half = 8'd21;
  logic [7:0] osc_half = 8'd64;
  logic ref_clk, xtal, osc, feed, dout, cko, los_flag, lol_flag, ple, irq;
  logic [1:0] rate_sel;
  logic [1:0] ref_sel;
  logic [31:0] rd;
  logic slv;
  logic [8:0] modes [5] = '{9'h000, 9'h040, 9'h080, 9'h020, 9'h0c0};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  cdrlc_top #(.WIN_REFS(WIN)) i_cdrlc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .los_comparator_in(los_in), .ref_clock_in(ref_clk),
    .crystal_pin_a(xtal), .osc_div_in(osc), .quantizer_data_in(quant), .test_data_in(tdata),
    .cdr_data_in(cdata), .cdr_clk_in(cclk), .cdr_feed_data(feed), .recovered_data_out(dout),
    .recovered_clk_out(cko), .signal_lost_flag(los_flag), .lock_lost_flag(lol_flag),
    .phase_loop_enable(ple), .rate_div_select(rate_sel), .ref_divider_select(ref_sel),
    .irq(irq));

  cdrlc_far_end i_cdrlc_far_end (.pclk(pclk), .ref_half(ref_half), .osc_half(osc_half),
    .ref_clock_in(ref_clk), .crystal_pin_a(xtal), .osc_div_in(osc));

  initial
  begin
    forever #2 pclk = ~pclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      stop_test();
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task path(input logic [8:0] c, input logic [3:0] p);
    logic mute;
    apb(1'b1, `CDRLC_ADDR_CTRL, {23'h0, c});
    {quant, tdata, cdata, cclk} <= p;
    repeat (2) @(posedge pclk);
    #1;
    mute = c[5] | (c[8] & los_flag);
    check({feed, dout, cko}, {(c[7] & ~c[6]) ? p[2] : p[3],
      mute ? 1'b0 : (c[6] ? p[3] : p[1]), mute ? 1'b0 : p[0]});
  endtask

  task wait_lol(input logic v);
    for (int n = 0; n < 4 * WCYC && lol_flag !== v; n++)
      @(posedge pclk);
    #1;
    check({lol_flag, ple}, {v, ~v});
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check({lol_flag, ple, irq, los_flag}, 4'b1000);
    apb(1'b1, `CDRLC_ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, `CDRLC_ADDR_STATUS, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    check(slv, 1'b1);
    // Source, frequency and rate selects in every combination
    for (int i = 0; i < 32; i++)
    begin
      apb(1'b1, `CDRLC_ADDR_CTRL, i);
      #1;
      check({rate_sel, ref_sel}, {i[4:3], i[0] ? i[2:1] : 2'b00});
    end
    foreach (modes[m])
    begin
      path(modes[m], 4'b1010);
      path(modes[m], 4'b0101);
    end
    // Masked event must not reach irq until the mask opens
    apb(1'b1, `CDRLC_ADDR_MASK, 32'h0);
    los_in <= 1'b1;
    for (int n = 0; n < 75 && los_flag !== 1'b1; n++)
      @(posedge pclk);
    #1;
    check({los_flag, irq}, 2'b10);
    path(9'h100, 4'b1011);
    apb(1'b1, `CDRLC_ADDR_MASK, 32'h7);
    #1;
    check(irq, 1'b1);
    apb(1'b0, `CDRLC_ADDR_EVENT, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `CDRLC_ADDR_EVENT, 32'h0);
    #1;
    check(rd, 32'h0);
    check(irq, 1'b0);
    los_in <= 1'b0;
    for (int n = 0; n < 75 && los_flag !== 1'b0; n++)
      @(posedge pclk);
    #1;
    check(los_flag, 1'b0);
    // Crystal reference, native rate
    apb(1'b1, `CDRLC_ADDR_CTRL, 32'h0);
    osc_half <= 8'd60;
    wait_lol(1'b0);
    check(irq, 1'b1);
    apb(1'b0, `CDRLC_ADDR_STATUS, 32'h0);
    check(rd, 32'h4);
    apb(1'b0, `CDRLC_ADDR_COUNT, 32'h0);
    check(rd, WIN * 7 / 10);
    apb(1'b0, `CDRLC_ADDR_EVENT, 32'h0);
    check(rd, 32'h4);
    // Oscillator drifts well beyond the release threshold
    osc_half <= 8'd64;
    wait_lol(1'b1);
    apb(1'b0, `CDRLC_ADDR_EVENT, 32'h0);
    check(rd, 32'h2);
    // Reference pin at twice the base rate
    apb(1'b1, `CDRLC_ADDR_CTRL, 32'h3);
    osc_half <= 8'd60;
    wait_lol(1'b0);
    apb(1'b0, `CDRLC_ADDR_COUNT, 32'h0);
    check(rd, WIN * 7 / 10);
    // Wrapper rate from the same reference
    osc_half <= 8'd56;
    apb(1'b1, `CDRLC_ADDR_CTRL, 32'h13);
    repeat (2 * WCYC) @(posedge pclk);
    wait_lol(1'b0);
    apb(1'b0, `CDRLC_ADDR_COUNT, 32'h0);
    check(rd, WIN * 3 / 4);
    stop_test();
  end
endmodule // tb_cdr_lock_and_path_control
